// ==== hdl/exc_pkg.sv ====
// Constants shared by the exception arbitration and vectoring logic
package exc_pkg;
  localparam int ADDR_W = 32;
  localparam int VEC_W  = 8;
  // Vector numbers
  localparam logic [7:0] VEC_RESET    = 8'h00;
  localparam logic [7:0] VEC_ILLEGAL  = 8'h04;
  localparam logic [7:0] VEC_TRACE    = 8'h05;
  localparam logic [7:0] VEC_NMI      = 8'h07;
  localparam logic [7:0] VEC_TRAP0    = 8'h08;
  localparam logic [7:0] VEC_CPU_AERR = 8'h0c;
  localparam logic [7:0] VEC_DMA_AERR = 8'h0d;
  localparam logic [7:0] VEC_SLEEP    = 8'h12;
  // Bytes per vector entry in advanced mode, as a shift
  localparam int VEC_SHIFT = 2;
  // Interrupt control mode that permits trace
  localparam logic [1:0] ICM_TRACE = 2'h2;
  // Reset values
  localparam logic [31:0] VBR_RESET = 32'h0000_0000;
  localparam logic [2:0]  IMASK_RESET = 3'h7;
  // Address map: upper region and on-chip RAM window
  localparam logic [23:0] EXT_REGION_LO = 24'h80_0000;
  localparam logic [23:0] EXT_REGION_HI = 24'hfe_ffff;
  localparam logic [23:0] RAM_LO        = 24'hff_2000;
  localparam logic [23:0] RAM_HI        = 24'hff_bfff;
  // Source indices, highest priority first
  localparam int SRC_RESET = 0;
  localparam int SRC_ILL   = 1;
  localparam int SRC_TRACE = 2;
  localparam int SRC_AERR  = 3;
  localparam int SRC_IRQ   = 4;
  localparam int SRC_SLEEP = 5;
  localparam int SRC_TRAP  = 6;
  localparam int NSRC      = 7;
  typedef enum logic [1:0] {
    SPACE_INTERNAL,
    SPACE_EXTERNAL,
    SPACE_RESERVED,
    SPACE_RAM
  } space_t;
endpackage

// ==== hdl/pend_flag.sv ====
`timescale 1ns/1ns
// One pending-request flag: held until taken or withdrawn
module pend_flag (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic set_i,
  input  wire logic take_i,
  input  wire logic withdraw_i,
  // State
  output logic      pend_o
);
  // Set wins over take and withdraw
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pend_o <= 1'b0;
    end else if (set_i) begin
      pend_o <= 1'b1;
    end else if (take_i || withdraw_i) begin
      pend_o <= 1'b0;
    end
  end
endmodule

// ==== hdl/addr_space_decode.sv ====
`timescale 1ns/1ns
// Address space classification for the upper region and on-chip RAM
module addr_space_decode
  import exc_pkg::*;
(
  // Address in
  input  wire logic [23:0]    addr_i,
  // Configuration
  input  wire logic           external_bus_enable_i,
  input  wire logic           onchip_ram_enable_i,
  // Result
  output exc_pkg::space_t     space_o
);
  // Region classification
  always_comb begin
    space_o = SPACE_INTERNAL;
    if (addr_i >= EXT_REGION_LO && addr_i <= EXT_REGION_HI) begin
      space_o = external_bus_enable_i ? SPACE_EXTERNAL
                                      : SPACE_RESERVED;
    end else if (addr_i >= RAM_LO && addr_i <= RAM_HI) begin
      space_o = onchip_ram_enable_i ? SPACE_RAM
                                    : SPACE_EXTERNAL;
    end
  end
endmodule

// ==== hdl/exception_priority_vectoring.sv ====
`timescale 1ns/1ns
// Exception arbitration, vector address forming and handler fetch
module exception_priority_vectoring
  import exc_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  // Reset sources
  input  wire logic                reset_pin_n_i,
  input  wire logic                wdt_overflow_i,
  // Pipeline events
  input  wire logic                insn_boundary_i,
  input  wire logic                illegal_opcode_i,
  input  wire logic                sleep_exec_i,
  input  wire logic                trap_exec_i,
  input  wire logic [1:0]          trap_code_i,
  input  wire logic                rte_done_i,
  input  wire logic                ctrl_reg_instr_done_i,
  input  wire logic                cpu_addr_err_i,
  input  wire logic                dma_addr_err_i,
  // Interrupt controller
  input  wire logic                irq_req_i,
  input  wire logic                irq_is_nmi_i,
  input  wire logic [7:0]          irq_vector_i,
  input  wire logic                irq_withdraw_i,
  // Configuration
  input  wire logic [1:0]          int_ctrl_mode_i,
  input  wire logic                software_standby_select_i,
  input  wire logic                sleep_interrupt_enable_i,
  input  wire logic                vbr_we_i,
  input  wire logic [31:0]         vbr_wdata_i,
  input  wire logic                trace_we_i,
  input  wire logic                trace_wdata_i,
  input  wire logic                external_bus_enable_i,
  input  wire logic                onchip_ram_enable_i,
  input  wire logic [23:0]         probe_addr_i,
  // Vector fetch
  output logic                     vec_rd_o,
  output logic [31:0]              vec_addr_o,
  input  wire logic                vec_ack_i,
  input  wire logic [31:0]         vec_rdata_i,
  // Results
  output logic                     in_reset_o,
  output logic                     exc_busy_o,
  output logic [7:0]               exc_vector_o,
  output logic                     pc_load_o,
  output logic [31:0]              pc_o,
  output logic [31:0]              vector_base_reg_o,
  output logic                     trace_bit_o,
  output logic [2:0]               imask_o,
  output exc_pkg::space_t          probe_space_o
);
  typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_FETCH} state_t;

  state_t            state;
  logic              pin_s1;
  logic              pin_s2;
  logic              pin_prev;
  logic              wdt_s1;
  logic              wdt_s2;
  logic              wdt_prev;
  logic              reset_start;
  logic              irq_blocked;
  logic              aerr_is_dma;
  logic [1:0]        trap_code;
  logic [7:0]        irq_vec;
  logic [NSRC-1:0]   set;
  logic [NSRC-1:0]   pend;
  logic [NSRC-1:0]   take;
  logic [NSRC-1:0]   wdraw;
  logic [NSRC-1:0]   grant;
  logic              grant_any;
  logic [7:0]        next_vec;
  logic [31:0]       next_addr;
  logic              run_ok;
  exc_pkg::space_t   space;

  // Synchronise reset pin and watchdog overflow
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_s1   <= 1'b0;
      pin_s2   <= 1'b0;
      pin_prev <= 1'b0;
      wdt_s1   <= 1'b0;
      wdt_s2   <= 1'b0;
      wdt_prev <= 1'b0;
    end else begin
      pin_s1   <= reset_pin_n_i;
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2;
      wdt_s1   <= wdt_overflow_i;
      wdt_s2   <= wdt_s1;
      wdt_prev <= wdt_s2;
    end
  end

  // Rising pin edge or overflow pulse starts reset handling
  assign reset_start = (pin_s2 && !pin_prev)
                     || (wdt_s2 && !wdt_prev);

  // Requests may be posted while the program runs
  assign run_ok = (state != ST_RESET);

  // Request conditions per source
  always_comb begin
    set = '0;
    set[SRC_RESET] = reset_start;
    set[SRC_ILL]   = run_ok && illegal_opcode_i;
    set[SRC_TRACE] = run_ok && insn_boundary_i && trace_bit_o
                     && int_ctrl_mode_i == ICM_TRACE
                     && !rte_done_i;
    set[SRC_AERR]  = run_ok && insn_boundary_i
                     && (aerr_is_dma || cpu_addr_err_i || dma_addr_err_i);
    set[SRC_IRQ]   = run_ok && insn_boundary_i && irq_req_i
                     && !irq_blocked
                     && !ctrl_reg_instr_done_i;
    set[SRC_SLEEP] = run_ok && sleep_exec_i
                     && !software_standby_select_i
                     && sleep_interrupt_enable_i;
    set[SRC_TRAP]  = run_ok && trap_exec_i;
  end

  // Address errors seen mid-instruction are held until the boundary
  logic aerr_cpu_seen;
  always_ff @(posedge core_clk_i) begin
    if (rst_i || state == ST_RESET) begin
      aerr_cpu_seen <= 1'b0;
      aerr_is_dma   <= 1'b0;
    end else if (cpu_addr_err_i || dma_addr_err_i) begin
      aerr_cpu_seen <= aerr_cpu_seen || cpu_addr_err_i;
      aerr_is_dma   <= 1'b1;
    end else if (set[SRC_AERR]) begin
      aerr_cpu_seen <= 1'b0;
      aerr_is_dma   <= 1'b0;
    end
  end

  // Record which address error source is waiting
  logic aerr_cpu_pend;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      aerr_cpu_pend <= 1'b0;
    end else if (set[SRC_AERR]) begin
      aerr_cpu_pend <= aerr_cpu_seen || cpu_addr_err_i;
    end
  end

  // Interrupt suppression after reset handling, until the next instruction boundary
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_blocked <= 1'b1;
    end else if (state == ST_FETCH && exc_vector_o == VEC_RESET) begin
      irq_blocked <= 1'b1;
    end else if (insn_boundary_i) begin
      irq_blocked <= 1'b0;
    end
  end

  // Latch trap code and interrupt vector with their requests
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      trap_code <= 2'h0;
      irq_vec   <= VEC_NMI;
    end else begin
      if (set[SRC_TRAP]) begin
        trap_code <= trap_code_i;
      end
      if (set[SRC_IRQ]) begin
        irq_vec <= irq_is_nmi_i ? VEC_NMI : irq_vector_i;
      end
    end
  end

  // Only the interrupt source may withdraw
  assign wdraw = {{(NSRC - SRC_IRQ - 1){1'b0}}, irq_withdraw_i,
                  {SRC_IRQ{1'b0}}};

  // One pending flag per source
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_pend
      pend_flag u_pend (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i || (g != SRC_RESET && state == ST_RESET)),
        .set_i      (set[g]),
        .take_i     (take[g]),
        .withdraw_i (wdraw[g]),
        .pend_o     (pend[g])
      );
    end
  endgenerate

  // Fixed priority: lowest index wins
  always_comb begin
    grant = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        grant = '0;
        grant[i] = 1'b1;
      end
    end
  end
  assign grant_any = |grant;
  assign take = (state == ST_RUN || (state == ST_RESET && grant[SRC_RESET]))
                ? grant : '0;

  // Vector number of the granted source
  always_comb begin
    next_vec = VEC_RESET;
    case (1'b1)
      grant[SRC_RESET]: next_vec = VEC_RESET;
      grant[SRC_ILL]:   next_vec = VEC_ILLEGAL;
      grant[SRC_TRACE]: next_vec = VEC_TRACE;
      grant[SRC_AERR]:  next_vec = aerr_cpu_pend ? VEC_CPU_AERR
                                                 : VEC_DMA_AERR;
      grant[SRC_IRQ]:   next_vec = irq_vec;
      grant[SRC_SLEEP]: next_vec = VEC_SLEEP;
      grant[SRC_TRAP]:  next_vec = VEC_TRAP0 + {6'h00, trap_code};
      default:          next_vec = VEC_RESET;
    endcase
  end

  // Table address: bare offset or base plus offset
  always_comb begin
    next_addr = {22'h000000, next_vec, 2'h0};
    if (!(grant[SRC_RESET] ||
          (grant[SRC_AERR] && aerr_cpu_pend))) begin
      next_addr = vector_base_reg_o + next_addr;
    end
  end

  // Control flow between reset, run and vector fetch
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= ST_RESET;
    end else if (!pin_s2) begin
      state <= ST_RESET;
    end else begin
      case (state)
        ST_RESET: if (grant[SRC_RESET]) state <= ST_FETCH;
        ST_RUN:   if (grant_any) state <= ST_FETCH;
        ST_FETCH: if (vec_ack_i) state <= ST_RUN;
        default:  state <= ST_RESET;
      endcase
    end
  end

  // Vector fetch request and address
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !pin_s2) begin
      vec_rd_o     <= 1'b0;
      vec_addr_o   <= 32'h0000_0000;
      exc_vector_o <= VEC_RESET;
    end else if (take != '0) begin
      vec_rd_o     <= 1'b1;
      vec_addr_o   <= grant[SRC_RESET] ? {22'h000000, VEC_RESET, 2'h0}
                                       : next_addr;
      exc_vector_o <= next_vec;
    end else if (state == ST_FETCH && vec_ack_i) begin
      vec_rd_o     <= 1'b0;
    end
  end

  // Handler address becomes the next program counter
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !pin_s2) begin
      pc_load_o <= 1'b0;
      pc_o      <= 32'h0000_0000;
    end else begin
      pc_load_o <= state == ST_FETCH && vec_ack_i;
      if (state == ST_FETCH && vec_ack_i) begin
        pc_o <= vec_rdata_i;
      end
    end
  end

  // Base register, trace bit and interrupt mask
  always_ff @(posedge core_clk_i) begin
    if (rst_i || state == ST_RESET || take[SRC_RESET]) begin
      vector_base_reg_o <= VBR_RESET;
      trace_bit_o       <= 1'b0;
      imask_o           <= IMASK_RESET;
    end else begin
      if (vbr_we_i) begin
        vector_base_reg_o <= vbr_wdata_i;
      end
      if (take[SRC_TRACE]) begin
        trace_bit_o <= 1'b0;
      end else if (trace_we_i) begin
        trace_bit_o <= trace_wdata_i;
      end
      if (take != '0) begin
        imask_o <= IMASK_RESET;
      end
    end
  end

  // Status outputs
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      in_reset_o <= 1'b1;
      exc_busy_o <= 1'b0;
    end else begin
      in_reset_o <= state == ST_RESET;
      exc_busy_o <= state == ST_FETCH;
    end
  end

  // Address space probe for bus masters
  addr_space_decode u_dec (
    .addr_i                (probe_addr_i),
    .external_bus_enable_i (external_bus_enable_i),
    .onchip_ram_enable_i   (onchip_ram_enable_i),
    .space_o               (space)
  );
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      probe_space_o <= SPACE_INTERNAL;
    end else begin
      probe_space_o <= space;
    end
  end

  // Fetch follows a take within one cycle
  property p_take_fetch;
    @(posedge core_clk_i) disable iff (rst_i || !pin_s2)
      (take != '0) |=> vec_rd_o;
  endproperty
  a_take_fetch: assert property (p_take_fetch)
    else $error("vector fetch not raised after take");

  // Reset grant gives bare vector zero
  property p_reset_vec;
    @(posedge core_clk_i) disable iff (rst_i || !pin_s2)
      take[SRC_RESET] |=> (vec_addr_o == 32'h0 && exc_vector_o == VEC_RESET);
  endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("reset vector address not zero");

  // Only one source granted at a time
  property p_onehot;
    @(posedge core_clk_i) disable iff (rst_i)
      $onehot0(grant);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("more than one source granted");

  // Pin low holds reset state
  property p_hold;
    @(posedge core_clk_i) disable iff (rst_i)
      !pin_s2 ##1 !pin_s2 |=> in_reset_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("not in reset while pin low");

  // Acked fetch loads PC with the read data
  property p_pc;
    @(posedge core_clk_i) disable iff (rst_i || !pin_s2)
      (state == ST_FETCH && vec_ack_i) |=>
        (pc_load_o && pc_o == $past(vec_rdata_i));
  endproperty
  a_pc: assert property (p_pc)
    else $error("pc not loaded from vector");

  // Any reset take, pin or watchdog, restores base, trace and mask
  property p_reset_clear;
    @(posedge core_clk_i) disable iff (rst_i || !pin_s2)
      take[SRC_RESET] |=> (vector_base_reg_o == VBR_RESET && !trace_bit_o
                           && imask_o == IMASK_RESET);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset take did not clear control state");
endmodule

// ==== bench/vec_table_model.sv ====
`timescale 1ns/1ns
// Vector table memory model answering handler address fetches
module vec_table_model (
  // Clock
  input  wire logic        core_clk_i,
  // Answer latency in cycles
  input  wire logic [3:0]  wait_i,
  // Fetch request
  input  wire logic        vec_rd_i,
  input  wire logic [31:0] vec_addr_i,
  // Answer
  output logic             vec_ack_o,
  output logic [31:0]      vec_rdata_o
);
  logic [3:0] cnt;

  // Entry holds the inverted address; idle data toggles every cycle
  always @(posedge core_clk_i) begin
    if (vec_rd_i && !vec_ack_o && cnt == wait_i) begin
      vec_ack_o   <= 1'b1;
      vec_rdata_o <= ~vec_addr_i;
      cnt         <= 4'h0;
    end else begin
      vec_ack_o   <= 1'b0;
      vec_rdata_o <= ~vec_rdata_o;
      cnt         <= (vec_rd_i && !vec_ack_o) ? cnt + 4'h1 : 4'h0;
    end
  end

  // Start idle
  initial begin
    vec_ack_o   = 1'b0;
    vec_rdata_o = 32'h0;
    cnt         = 4'h0;
  end
endmodule

// ==== bench/exception_priority_vectoring_bench.sv ====
`timescale 1ns/1ns
// Self-checking bench for the exception arbitration and vectoring unit
module exception_priority_vectoring_bench;
  import exc_pkg::*;
  localparam logic [31:0] VBASE = 32'h0001_0000;
  logic core_clk_i, rst_i, reset_pin_n_i, wdt_overflow_i, insn_boundary_i;
  logic illegal_opcode_i, sleep_exec_i, trap_exec_i, rte_done_i;
  logic ctrl_reg_instr_done_i, cpu_addr_err_i, dma_addr_err_i, irq_req_i;
  logic irq_is_nmi_i, irq_withdraw_i, software_standby_select_i;
  logic sleep_interrupt_enable_i, vbr_we_i, trace_we_i, trace_wdata_i;
  logic external_bus_enable_i, onchip_ram_enable_i, vec_ack_i;
  logic vec_rd_o, in_reset_o, exc_busy_o, pc_load_o, trace_bit_o;
  logic [1:0]  trap_code_i, int_ctrl_mode_i;
  logic [7:0]  irq_vector_i, exc_vector_o;
  logic [31:0] vbr_wdata_i, vec_rdata_i, vec_addr_o, pc_o;
  logic [31:0] vector_base_reg_o;
  logic [23:0] probe_addr_i;
  logic [2:0]  imask_o;
  logic [3:0]  wait_cyc;
  space_t      probe_space_o;
  int          err_count;
  int          num_checks;

  exception_priority_vectoring i_exception_priority_vectoring (
    .core_clk_i (core_clk_i), .rst_i (rst_i),
    .reset_pin_n_i (reset_pin_n_i), .wdt_overflow_i (wdt_overflow_i),
    .insn_boundary_i (insn_boundary_i),
    .illegal_opcode_i (illegal_opcode_i),
    .sleep_exec_i (sleep_exec_i), .trap_exec_i (trap_exec_i),
    .trap_code_i (trap_code_i), .rte_done_i (rte_done_i),
    .ctrl_reg_instr_done_i (ctrl_reg_instr_done_i),
    .cpu_addr_err_i (cpu_addr_err_i), .dma_addr_err_i (dma_addr_err_i),
    .irq_req_i (irq_req_i), .irq_is_nmi_i (irq_is_nmi_i),
    .irq_vector_i (irq_vector_i), .irq_withdraw_i (irq_withdraw_i),
    .int_ctrl_mode_i (int_ctrl_mode_i),
    .software_standby_select_i (software_standby_select_i),
    .sleep_interrupt_enable_i (sleep_interrupt_enable_i),
    .vbr_we_i (vbr_we_i), .vbr_wdata_i (vbr_wdata_i),
    .trace_we_i (trace_we_i), .trace_wdata_i (trace_wdata_i),
    .external_bus_enable_i (external_bus_enable_i),
    .onchip_ram_enable_i (onchip_ram_enable_i),
    .probe_addr_i (probe_addr_i),
    .vec_rd_o (vec_rd_o), .vec_addr_o (vec_addr_o),
    .vec_ack_i (vec_ack_i), .vec_rdata_i (vec_rdata_i),
    .in_reset_o (in_reset_o), .exc_busy_o (exc_busy_o),
    .exc_vector_o (exc_vector_o), .pc_load_o (pc_load_o), .pc_o (pc_o),
    .vector_base_reg_o (vector_base_reg_o), .trace_bit_o (trace_bit_o),
    .imask_o (imask_o), .probe_space_o (probe_space_o)
  );

  vec_table_model i_vec_table_model (
    .core_clk_i  (core_clk_i),
    .wait_i      (wait_cyc),
    .vec_rd_i    (vec_rd_o),
    .vec_addr_i  (vec_addr_o),
    .vec_ack_o   (vec_ack_i),
    .vec_rdata_o (vec_rdata_i)
  );

  // 125 MHz clock
  always #4 core_clk_i = ~core_clk_i;

  // Step to just after the next rising edge
  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask

  // Compare two values, count and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expect one vector fetch and the handler load that follows
  task automatic fetch(input logic [7:0] v, input logic [31:0] a);
    int i;
    for (i = 0; i < 20 && vec_rd_o !== 1'b1; i++) tick();
    chk({31'h0, vec_rd_o}, 32'h1);
    chk({24'h0, exc_vector_o}, {24'h0, v});
    chk(vec_addr_o, a);
    for (i = 0; i < 40 && pc_load_o !== 1'b1; i++) tick();
    chk({31'h0, pc_load_o}, 32'h1);
    chk({31'h0, exc_busy_o}, 32'h1);
    chk(pc_o, ~a);
    tick();
  endtask

  // Expect no fetch for n cycles
  task automatic none(input int n);
    repeat (n) begin
      tick();
      chk({31'h0, vec_rd_o}, 32'h0);
    end
  endtask

  // Pulse the instruction boundary
  task automatic bound();
    insn_boundary_i = 1;
    tick();
    insn_boundary_i = 0;
  endtask

  // Reset hold, release and reset vector fetch
  task automatic t_reset();
    repeat (3) @(posedge core_clk_i);
    #1;
    chk({31'h0, in_reset_o}, 32'h1);
    chk({29'h0, imask_o}, 32'h7);
    rst_i = 0;
    none(8);
    chk({31'h0, in_reset_o}, 32'h1);
    reset_pin_n_i = 1;
    fetch(VEC_RESET, 32'h0);
    chk({31'h0, in_reset_o}, 32'h0);
    bound();
    none(3);
  endtask

  // All trap codes with rising answer latency
  task automatic t_trap();
    vbr_wdata_i = VBASE;
    vbr_we_i = 1;
    tick();
    vbr_we_i = 0;
    tick();
    chk(vector_base_reg_o, VBASE);
    for (int c = 0; c < 4; c++) begin
      wait_cyc = 4'(c * 3);
      trap_exec_i = 1;
      trap_code_i = 2'(c);
      tick();
      trap_exec_i = 0;
      fetch(8'(8 + c), VBASE + 32'(32 + 4 * c));
    end
  endtask

  // Six sources at once are taken one by one in order
  task automatic t_prio();
    trace_wdata_i = 1;
    trace_we_i = 1;
    tick();
    trace_we_i = 0;
    cpu_addr_err_i = 1;
    tick();
    cpu_addr_err_i = 0;
    none(3);
    insn_boundary_i = 1;
    illegal_opcode_i = 1;
    sleep_exec_i = 1;
    trap_exec_i = 1;
    trap_code_i = 2'h1;
    irq_req_i = 1;
    irq_vector_i = 8'h40;
    tick();
    {insn_boundary_i, illegal_opcode_i, sleep_exec_i} = '0;
    {trap_exec_i, irq_req_i} = '0;
    fetch(VEC_ILLEGAL, VBASE + 32'h10);
    fetch(VEC_TRACE, VBASE + 32'h14);
    fetch(VEC_CPU_AERR, 32'h30);
    fetch(8'h40, VBASE + 32'h100);
    fetch(VEC_SLEEP, VBASE + 32'h48);
    fetch(VEC_TRAP0 + 8'h1, VBASE + 32'h24);
    none(6);
  endtask

  // Sleep refused unless standby select is 0 and enable is 1
  task automatic t_sleep_off();
    software_standby_select_i = 1;
    sleep_exec_i = 1;
    tick();
    sleep_exec_i = 0;
    none(6);
    software_standby_select_i = 0;
    sleep_interrupt_enable_i = 0;
    sleep_exec_i = 1;
    tick();
    sleep_exec_i = 0;
    none(6);
    sleep_interrupt_enable_i = 1;
  endtask

  // Trace blocked after return and outside mode 2; DMA address error
  task automatic t_trace();
    trace_we_i = 1;
    tick();
    trace_we_i = 0;
    rte_done_i = 1;
    bound();
    rte_done_i = 0;
    none(6);
    int_ctrl_mode_i = 2'h0;
    bound();
    none(6);
    int_ctrl_mode_i = ICM_TRACE;
    dma_addr_err_i = 1;
    tick();
    dma_addr_err_i = 0;
    bound();
    fetch(VEC_TRACE, VBASE + 32'h14);
    fetch(VEC_DMA_AERR, VBASE + 32'h34);
    chk({31'h0, trace_bit_o}, 32'h0);
  endtask

  // Interrupt after control instruction, then a withdrawn request
  task automatic t_irq();
    irq_req_i = 1;
    irq_is_nmi_i = 1;
    irq_vector_i = VEC_NMI;
    none(3);
    ctrl_reg_instr_done_i = 1;
    bound();
    ctrl_reg_instr_done_i = 0;
    none(4);
    bound();
    irq_req_i = 0;
    fetch(VEC_NMI, VBASE + 32'h1c);
    irq_req_i = 1;
    irq_is_nmi_i = 0;
    irq_vector_i = 8'h41;
    illegal_opcode_i = 1;
    bound();
    {irq_req_i, illegal_opcode_i} = '0;
    irq_withdraw_i = 1;
    tick();
    irq_withdraw_i = 0;
    fetch(VEC_ILLEGAL, VBASE + 32'h10);
    none(6);
  endtask

  // One address class probe
  task automatic map1(input logic [23:0] a, input logic e, input logic r,
                      input space_t s);
    probe_addr_i = a;
    external_bus_enable_i = e;
    onchip_ram_enable_i = r;
    tick();
    tick();
    chk({30'h0, probe_space_o}, {30'h0, s});
  endtask

  // Watchdog reset clears base register and trace bit
  task automatic t_wdt();
    trace_we_i = 1;
    tick();
    trace_we_i = 0;
    wdt_overflow_i = 1;
    repeat (3) tick();
    wdt_overflow_i = 0;
    fetch(VEC_RESET, 32'h0);
    chk(vector_base_reg_o, 32'h0);
    chk({31'h0, trace_bit_o}, 32'h0);
    chk({29'h0, imask_o}, 32'h7);
  endtask

  // Print counts and verdict, then stop
  task automatic test_done();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Cut a hang short
  initial begin
    repeat (5000) @(posedge core_clk_i);
    err_count++;
    test_done();
  end

  // Main sequence
  initial begin
    err_count = 0;
    num_checks = 0;
    core_clk_i = 0;
    rst_i = 1;
    {reset_pin_n_i, wdt_overflow_i, insn_boundary_i, illegal_opcode_i} = '0;
    {sleep_exec_i, trap_exec_i, rte_done_i, ctrl_reg_instr_done_i} = '0;
    {cpu_addr_err_i, dma_addr_err_i, irq_req_i, irq_is_nmi_i} = '0;
    {irq_withdraw_i, software_standby_select_i, vbr_we_i} = '0;
    {trace_we_i, trace_wdata_i, external_bus_enable_i} = '0;
    {trap_code_i, irq_vector_i, vbr_wdata_i, probe_addr_i} = '0;
    sleep_interrupt_enable_i = 1;
    onchip_ram_enable_i = 1;
    int_ctrl_mode_i = ICM_TRACE;
    wait_cyc = 4'h0;
    t_reset();
    t_trap();
    t_prio();
    t_sleep_off();
    t_trace();
    t_irq();
    map1(24'h80_0000, 1'b1, 1'b1, SPACE_EXTERNAL);
    map1(24'hfe_ffff, 1'b0, 1'b1, SPACE_RESERVED);
    map1(24'h7f_ffff, 1'b0, 1'b1, SPACE_INTERNAL);
    map1(24'hff_2000, 1'b0, 1'b1, SPACE_RAM);
    map1(24'hff_bfff, 1'b1, 1'b0, SPACE_EXTERNAL);
    t_wdt();
    test_done();
  end
endmodule
